// ### hdl/jdr_top.sv
`timescale 1ns/1ps
module jdr_top
   import jdr_pkg::*;
#(
   parameter int IR_WIDTH = IR_W,
   parameter bit MASTER_DIE = 1'b1,
   // Arbitrary identity value; bit zero is forced to one anyway.
   parameter logic [31:0] ID_WORD = 32'h0a5c3e01
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic tdo_oe_n,
   input wire jdr_status_t status,
   input wire logic ident_load,
   input wire logic [DR_W-1:0] ident_word,
   input wire logic rd_load,
   input wire logic [DR_W-1:0] rd_word,
   output logic cfg_wr_valid,
   output logic [DR_W-1:0] cfg_wr_word,
   output jdr_bridge_t bridge,
   output logic [CHAINS-1:0] user_sel,
   input wire logic [CHAINS-1:0] user_tdo,
   output logic [CHAINS-1:0] dr_shift_clock_out,
   output logic user_tdi,
   output logic user_tck,
   output logic user_tms
);
   jdr_tap_t state_reg;
   jdr_tap_t state_next;
   logic rst_meta_reg;
   logic rst_tck_reg;
   jdr_status_t st_meta_reg;
   jdr_status_t st_sync_reg;
   logic [IR_WIDTH-1:0] ir_shift_reg;
   logic [IR_WIDTH-1:0] ir_reg;
   logic [IR_WIDTH-1:0] ir_next;
   logic [IR_WIDTH-1:0] ir_cap;
   logic [DR_W-1:0] dr_shift_reg;
   logic byp_reg;
   logic [CHAINS-1:0] sel_reg;
   logic [CHAINS-1:0] user_hit;
   logic [CHAINS-1:0] dr_shift_clock_out_en_reg;
   logic user_tdo_mux;
   logic sel_ident;
   logic sel_design;
   logic sel_cfg_load;
   logic sel_cfg_read;
   logic sel_bypass;
   logic tdo_reg;
   logic tdo_oe_n_reg;
   jdr_bridge_t bridge_reg;
   logic [DR_W-1:0] ident_reg;
   logic [DR_W-1:0] rd_hold_reg;
   logic rd_tgl_reg;
   logic rd_tgl_meta_reg;
   logic rd_tgl_sync_reg;
   logic rd_tgl_seen_reg;
   logic [DR_W-1:0] rd_word_tck_reg;
   logic [DR_W-1:0] cfg_hold_reg;
   logic cfg_tgl_reg;
   logic cfg_tgl_meta_reg;
   logic cfg_tgl_sync_reg;
   logic cfg_tgl_seen_reg;
   logic cfg_wr_valid_reg;
   logic [DR_W-1:0] cfg_wr_word_reg;

   // The TCK domain gets its own copy of the reset.
   always_ff @(posedge tck) begin
      rst_meta_reg <= srst;
      rst_tck_reg <= rst_meta_reg;
   end

   // Status levels come from the system clock domain.
   always_ff @(posedge tck) begin
      st_meta_reg <= status;
      st_sync_reg <= st_meta_reg;
   end

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         TS_RESET: state_next = tms ? TS_RESET : TS_IDLE;
         TS_IDLE: state_next = tms ? TS_SEL_DR : TS_IDLE;
         TS_SEL_DR: state_next = tms ? TS_SEL_IR : TS_CAP_DR;
         TS_CAP_DR: state_next = tms ? TS_EX1_DR : TS_SH_DR;
         TS_SH_DR: state_next = tms ? TS_EX1_DR : TS_SH_DR;
         TS_EX1_DR: state_next = tms ? TS_UPD_DR : TS_PAU_DR;
         TS_PAU_DR: state_next = tms ? TS_EX2_DR : TS_PAU_DR;
         TS_EX2_DR: state_next = tms ? TS_UPD_DR : TS_SH_DR;
         TS_UPD_DR: state_next = tms ? TS_SEL_DR : TS_IDLE;
         TS_SEL_IR: state_next = tms ? TS_RESET : TS_CAP_IR;
         TS_CAP_IR: state_next = tms ? TS_EX1_IR : TS_SH_IR;
         TS_SH_IR: state_next = tms ? TS_EX1_IR : TS_SH_IR;
         TS_EX1_IR: state_next = tms ? TS_UPD_IR : TS_PAU_IR;
         TS_PAU_IR: state_next = tms ? TS_EX2_IR : TS_PAU_IR;
         TS_EX2_IR: state_next = tms ? TS_UPD_IR : TS_SH_IR;
         TS_UPD_IR: state_next = tms ? TS_SEL_DR : TS_IDLE;
      endcase
   end

   always_ff @(posedge tck) begin
      if (rst_tck_reg) begin
         state_reg <= TS_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   always_comb begin
      ir_cap = '0;
      ir_cap[IR_DONE_BIT] = st_sync_reg.cfg_done;
      ir_cap[IR_INIT_BIT] = st_sync_reg.init_done;
      ir_cap[IR_ISCA_BIT] = st_sync_reg.insys_cfg_active_flag;
      ir_cap[IR_ISCF_BIT] = st_sync_reg.insys_cfg_finished_flag;
      ir_cap[1:0] = IR_CAP_FIXED;
      ir_next = ir_reg;
      if (state_reg == TS_RESET) begin
         ir_next = '0;
         ir_next[5:0] = OP_IDENT;
      end else if (state_reg == TS_UPD_IR) begin
         ir_next = ir_shift_reg;
      end
   end

   always_ff @(posedge tck) begin
      if (rst_tck_reg) begin
         ir_shift_reg <= '0;
      end else if (state_reg == TS_CAP_IR) begin
         ir_shift_reg <= ir_cap;
      end else if (state_reg == TS_SH_IR) begin
         ir_shift_reg <= {tdi, ir_shift_reg[IR_WIDTH-1:1]};
      end
   end

   always_ff @(posedge tck) begin
      if (rst_tck_reg) begin
         ir_reg <= '0;
         ir_reg[5:0] <= OP_IDENT;
      end else begin
         ir_reg <= ir_next;
      end
   end

   // Only the low six bits carry the opcode; wider parts extend above them.
   assign sel_ident = ir_reg[5:0] == OP_IDENT;
   assign sel_design = ir_reg[5:0] == OP_DESIGN_IDENT;
   assign sel_cfg_load = ir_reg[5:0] == OP_CFG_LOAD;
   assign sel_cfg_read = ir_reg[5:0] == OP_CFG_READ;
   // Reserved codes and unconfigured user chains fall back to bypass.
   assign sel_bypass = !(sel_ident || sel_design || sel_cfg_load || sel_cfg_read || (|sel_reg));

   genvar gi;
   generate
      for (gi = 0; gi < CHAINS; gi++) begin : g_chain
         // Each pass builds one chain's select register and gated shift clock, tied to its own user opcode.
         always_ff @(posedge tck) begin
            if (rst_tck_reg) begin
               sel_reg[gi] <= 1'b0;
            end else begin
               sel_reg[gi] <= MASTER_DIE && st_sync_reg.cfg_done && (ir_next[5:0] == USER_OPS[gi]);
            end
         end
         assign user_hit[gi] = sel_reg[gi] & user_tdo[gi];
         // Enable changes only while TCK is low, so the gated clock cannot glitch.
         always_ff @(negedge tck) begin
            if (rst_tck_reg) begin
               dr_shift_clock_out_en_reg[gi] <= 1'b0;
            end else begin
               dr_shift_clock_out_en_reg[gi] <= sel_reg[gi] && (state_reg == TS_CAP_DR || state_reg == TS_SH_DR);
            end
         end
         assign dr_shift_clock_out[gi] = tck & dr_shift_clock_out_en_reg[gi];
         chk_user_sel_track: assert property (@(posedge tck) disable iff (rst_tck_reg)
            !$past(st_sync_reg.cfg_done) |-> !sel_reg[gi])
            else $error("user select high before configuration done");
         chk_user_tdo_neg: assert property (@(negedge tck) disable iff (rst_tck_reg)
            (state_reg == TS_SH_DR && sel_reg[gi]) |=> tdo_reg == $past(user_tdo[gi]))
            else $error("user serial output not registered on falling edge");
      end
   endgenerate
   assign user_tdo_mux = |user_hit;

   always_ff @(posedge tck) begin
      if (rst_tck_reg) begin
         byp_reg <= 1'b0;
      end else if (state_reg == TS_CAP_DR) begin
         byp_reg <= 1'b0;
      end else if (state_reg == TS_SH_DR && sel_bypass) begin
         byp_reg <= tdi;
      end
   end

   always_ff @(posedge tck) begin
      if (rst_tck_reg) begin
         dr_shift_reg <= '0;
      end else if (state_reg == TS_CAP_DR) begin
         if (sel_ident) begin
            dr_shift_reg <= {ID_WORD[31:1], 1'b1};
         end else if (sel_design) begin
            // The word is stable once done is seen here, which lags its load.
            dr_shift_reg <= st_sync_reg.cfg_done ? ident_reg : DESIGN_IDENT_RST;
         end else if (sel_cfg_read) begin
            dr_shift_reg <= rd_word_tck_reg;
         end
      end else if (state_reg == TS_SH_DR) begin
         dr_shift_reg <= {tdi, dr_shift_reg[DR_W-1:1]};
      end
   end

   always_ff @(negedge tck) begin
      if (rst_tck_reg) begin
         tdo_reg <= 1'b0;
         tdo_oe_n_reg <= 1'b1;
      end else begin
         tdo_oe_n_reg <= !(state_reg == TS_SH_IR || state_reg == TS_SH_DR);
         if (state_reg == TS_SH_IR) begin
            tdo_reg <= ir_shift_reg[0];
         end else if (state_reg == TS_SH_DR) begin
            if (|sel_reg) begin
               tdo_reg <= user_tdo_mux;
            end else if (sel_bypass) begin
               tdo_reg <= byp_reg;
            end else begin
               tdo_reg <= dr_shift_reg[0];
            end
         end
      end
   end

   always_ff @(posedge tck) begin
      if (rst_tck_reg) begin
         bridge_reg <= '0;
      end else begin
         bridge_reg.reset <= state_next == TS_RESET;
         bridge_reg.update <= state_next == TS_UPD_DR;
         bridge_reg.shift <= state_next == TS_SH_DR;
         bridge_reg.capture <= state_next == TS_CAP_DR;
      end
   end

   // A finished load word is held here and announced by a toggle.
   always_ff @(posedge tck) begin
      if (rst_tck_reg) begin
         cfg_hold_reg <= '0;
         cfg_tgl_reg <= 1'b0;
      end else if (state_reg == TS_UPD_DR && sel_cfg_load) begin
         cfg_hold_reg <= dr_shift_reg;
         cfg_tgl_reg <= ~cfg_tgl_reg;
      end
   end

   always_ff @(posedge tck) begin
      if (rst_tck_reg) begin
         rd_tgl_meta_reg <= 1'b0;
         rd_tgl_sync_reg <= 1'b0;
         rd_tgl_seen_reg <= 1'b0;
         rd_word_tck_reg <= CFG_RD_RST;
      end else begin
         rd_tgl_meta_reg <= rd_tgl_reg;
         rd_tgl_sync_reg <= rd_tgl_meta_reg;
         rd_tgl_seen_reg <= rd_tgl_sync_reg;
         if (rd_tgl_sync_reg != rd_tgl_seen_reg) begin
            rd_word_tck_reg <= rd_hold_reg;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         ident_reg <= DESIGN_IDENT_RST;
      end else if (ident_load) begin
         ident_reg <= ident_word;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rd_hold_reg <= CFG_RD_RST;
         rd_tgl_reg <= 1'b0;
      end else if (rd_load) begin
         rd_hold_reg <= rd_word;
         rd_tgl_reg <= ~rd_tgl_reg;
      end
   end

   // Back-to-back loads must be spaced by a full scan, far longer than the crossing.
   always_ff @(posedge clk) begin
      if (srst) begin
         cfg_tgl_meta_reg <= 1'b0;
         cfg_tgl_sync_reg <= 1'b0;
         cfg_tgl_seen_reg <= 1'b0;
         cfg_wr_valid_reg <= 1'b0;
         cfg_wr_word_reg <= '0;
      end else begin
         cfg_tgl_meta_reg <= cfg_tgl_reg;
         cfg_tgl_sync_reg <= cfg_tgl_meta_reg;
         cfg_tgl_seen_reg <= cfg_tgl_sync_reg;
         cfg_wr_valid_reg <= cfg_tgl_sync_reg != cfg_tgl_seen_reg;
         if (cfg_tgl_sync_reg != cfg_tgl_seen_reg) begin
            cfg_wr_word_reg <= cfg_hold_reg;
         end
      end
   end

   assign tdo = tdo_reg;
   assign tdo_oe_n = tdo_oe_n_reg;
   assign bridge = bridge_reg;
   assign user_sel = sel_reg;
   assign cfg_wr_valid = cfg_wr_valid_reg;
   assign cfg_wr_word = cfg_wr_word_reg;
   // These are plain wires because the user side expects the live pins.
   assign user_tdi = tdi;
   assign user_tck = tck;
   assign user_tms = tms;

   sequence s_cap_ir;
      state_reg == TS_CAP_IR;
   endsequence
   sequence s_ir_loaded;
      ir_shift_reg[1:0] == IR_CAP_FIXED && ir_shift_reg[IR_DONE_BIT] == $past(st_sync_reg.cfg_done);
   endsequence

   chk_ir_cap_pattern: assert property (@(posedge tck) disable iff (rst_tck_reg)
      s_cap_ir |=> s_ir_loaded)
      else $error("instruction capture pattern wrong");
   chk_ir_init_bit: assert property (@(posedge tck) disable iff (rst_tck_reg)
      s_cap_ir |=> ir_shift_reg[IR_INIT_BIT] == $past(st_sync_reg.init_done))
      else $error("captured init bit wrong");
   chk_ir_shift_lsb: assert property (@(negedge tck) disable iff (rst_tck_reg)
      state_reg == TS_SH_IR |=> tdo_reg == $past(ir_shift_reg[0]))
      else $error("instruction shift not lsb first");
   chk_bypass_clear: assert property (@(posedge tck) disable iff (rst_tck_reg)
      state_reg == TS_CAP_DR |=> !byp_reg)
      else $error("bypass not cleared in capture");
   chk_bypass_path: assert property (@(posedge tck) disable iff (rst_tck_reg)
      (state_reg == TS_SH_DR && sel_bypass) |=> byp_reg == $past(tdi))
      else $error("bypass stage did not take tdi");
   chk_ident_word: assert property (@(posedge tck) disable iff (rst_tck_reg)
      (state_reg == TS_CAP_DR && sel_ident) |=> dr_shift_reg[0] && dr_shift_reg[31:1] == ID_WORD[31:1])
      else $error("identity word wrong");
   chk_design_blank: assert property (@(posedge tck) disable iff (rst_tck_reg)
      (state_reg == TS_CAP_DR && sel_design && !st_sync_reg.cfg_done) |=> dr_shift_reg == DESIGN_IDENT_RST)
      else $error("design ident not all ones when blank");
   chk_cfg_hold: assert property (@(posedge tck) disable iff (rst_tck_reg)
      (state_reg == TS_UPD_DR && sel_cfg_load) |=> cfg_hold_reg == $past(dr_shift_reg) && $changed(cfg_tgl_reg))
      else $error("config word not handed over");
   chk_bridge_decode: assert property (@(posedge tck) disable iff (rst_tck_reg)
      bridge_reg.shift == (state_reg == TS_SH_DR) && bridge_reg.capture == (state_reg == TS_CAP_DR))
      else $error("bridge decodes out of step with state");
   chk_cfg_pulse: assert property (@(posedge clk) disable iff (srst)
      cfg_wr_valid_reg |=> !cfg_wr_valid_reg)
      else $error("config write strobe longer than one cycle");
endmodule

// ### hdl/jdr_pkg.sv
package jdr_pkg;
   localparam int IR_W = 6;
   localparam int DR_W = 32;
   localparam int CHAINS = 4;
   localparam logic [5:0] OP_BYPASS = 6'h3f;
   localparam logic [5:0] OP_IDENT = 6'h09;
   localparam logic [5:0] OP_DESIGN_IDENT = 6'h08;
   localparam logic [5:0] OP_CFG_LOAD = 6'h05;
   localparam logic [5:0] OP_CFG_READ = 6'h04;
   // Entry 0 is user_scan_instr_one, entry 3 is user_scan_instr_four.
   localparam logic [3:0][5:0] USER_OPS = {6'h23, 6'h22, 6'h03, 6'h02};
   localparam int IR_DONE_BIT = 5;
   localparam int IR_INIT_BIT = 4;
   localparam int IR_ISCA_BIT = 3;
   localparam int IR_ISCF_BIT = 2;
   localparam logic [1:0] IR_CAP_FIXED = 2'h1;
   localparam logic [31:0] DESIGN_IDENT_RST = 32'hffffffff;
   localparam logic [31:0] CFG_RD_RST = 32'h00000000;

   typedef enum logic [15:0] {
      TS_RESET = 16'h0001,
      TS_IDLE = 16'h0002,
      TS_SEL_DR = 16'h0004,
      TS_CAP_DR = 16'h0008,
      TS_SH_DR = 16'h0010,
      TS_EX1_DR = 16'h0020,
      TS_PAU_DR = 16'h0040,
      TS_EX2_DR = 16'h0080,
      TS_UPD_DR = 16'h0100,
      TS_SEL_IR = 16'h0200,
      TS_CAP_IR = 16'h0400,
      TS_SH_IR = 16'h0800,
      TS_EX1_IR = 16'h1000,
      TS_PAU_IR = 16'h2000,
      TS_EX2_IR = 16'h4000,
      TS_UPD_IR = 16'h8000
   } jdr_tap_t;

   typedef struct packed {
      logic reset;
      logic update;
      logic shift;
      logic capture;
   } jdr_bridge_t;

   typedef struct packed {
      logic cfg_done;
      logic init_done;
      logic insys_cfg_active_flag;
      logic insys_cfg_finished_flag;
   } jdr_status_t;
endpackage

// ### bench/jdr_host.sv
`timescale 1ns/1ps
// Host model: tck rests low between frames and tdi rests high, as a pulled-up line would.
// The tdo line has a pull-up, so a released pin reads one rather than its last driven value.
module jdr_host (
   output logic tck,
   output logic tms,
   output logic tdi,
   output logic [2:0] boot_mode,
   input wire logic tdo,
   input wire logic tdo_oe_n
);
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
      boot_mode = 3'h5;
   end

   // One period of 15 ns; tdo is taken at the rise where the device samples tms and tdi.
   task automatic step(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      #7.5;
      q = (tdo_oe_n === 1'b0) ? tdo : 1'b1;
      tck = 1'b1;
      #7.5;
      tck = 1'b0;
   endtask

   task automatic walk(input logic [7:0] seq, input int n);
      logic q;
      for (int i = 0; i < n; i++) begin
         step(seq[i], 1'b1, q);
      end
   endtask

   // Five ones reach reset from any state, then one zero parks in idle.
   task automatic tap_reset();
      walk(8'h1f, 6);
   endtask

   task automatic shift(input logic [31:0] din, input int n, output logic [31:0] dout);
      logic q;
      dout = '0;
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], q);
         dout[i] = q;
      end
      walk(8'h01, 2);
   endtask

   // Three idle periods first give the status synchronisers edges to settle on.
   task automatic scan_ir(input logic [5:0] ir, output logic [5:0] cap);
      logic [31:0] w;
      walk(8'h18, 7);
      shift({26'h0, ir}, 6, w);
      cap = w[5:0];
   endtask

   task automatic scan_dr(input logic [31:0] din, input int n, output logic [31:0] dout);
      walk(8'h08, 6);
      shift(din, n, dout);
   endtask
endmodule

// ### bench/test_jdr_top.sv
`timescale 1ns/1ps
module test_jdr_top;
   import jdr_pkg::*;
   // Arbitrary identity value; bit zero is left clear so that its forcing shows.
   localparam logic [31:0] ID_SET = 32'h3c96e5a4;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic tck, tms, tdi, tdo, tdo_oe_n;
   jdr_status_t status = '0;
   logic ident_load = 1'b0;
   logic [DR_W-1:0] ident_word = '0;
   logic rd_load = 1'b0;
   logic [DR_W-1:0] rd_word = '0;
   logic cfg_wr_valid;
   logic [DR_W-1:0] cfg_wr_word;
   jdr_bridge_t bridge;
   logic [CHAINS-1:0] user_sel;
   logic [CHAINS-1:0] user_tdo = '1;
   logic [CHAINS-1:0] dr_shift_clock_out;
   logic user_tdi, user_tck, user_tms;
   int error_cnt = 0;
   int tests_run = 0;
   int cyc = 0;
   int wr_cnt = 0;
   logic [DR_W-1:0] wr_seen = '0;
   int dr_shift_clock_out_cnt [CHAINS] = '{default: 0};
   logic [2:0] boot_mode;
   int oe_cnt = 0;
   int shf_cnt = 0;
   int cap_cnt = 0;
   int upd_cnt = 0;

   jdr_host host (.tck(tck), .tms(tms), .tdi(tdi), .boot_mode(boot_mode), .tdo(tdo), .tdo_oe_n(tdo_oe_n));

   jdr_top #(.ID_WORD(ID_SET)) dut (.clk(clk), .srst(srst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
      .tdo_oe_n(tdo_oe_n), .status(status), .ident_load(ident_load), .ident_word(ident_word),
      .rd_load(rd_load), .rd_word(rd_word), .cfg_wr_valid(cfg_wr_valid), .cfg_wr_word(cfg_wr_word),
      .bridge(bridge), .user_sel(user_sel), .user_tdo(user_tdo), .dr_shift_clock_out(dr_shift_clock_out),
      .user_tdi(user_tdi), .user_tck(user_tck), .user_tms(user_tms));

   always #20 clk = ~clk;

   // Sampled on the falling edge, where the strobe and word launched at the rise are settled.
   always @(negedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         report_and_stop();
      end
      if (cfg_wr_valid === 1'b1) begin
         wr_cnt++;
         wr_seen = cfg_wr_word;
      end
   end

   for (genvar g = 0; g < CHAINS; g++) begin : g_dr_shift_clock_out
      always @(posedge dr_shift_clock_out[g]) begin
         dr_shift_clock_out_cnt[g]++;
      end
   end

   // The enable changes at the fall, so it is counted at the rise; the decodes the other way round.
   always @(posedge tck) begin
      if (tdo_oe_n === 1'b0) begin
         oe_cnt++;
      end
   end

   always @(negedge tck) begin
      if (bridge.shift === 1'b1) begin
         shf_cnt++;
      end
      if (bridge.capture === 1'b1) begin
         cap_cnt++;
      end
      if (bridge.update === 1'b1) begin
         upd_cnt++;
      end
   end

   task automatic chk_vec(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_cnt(input string what, input int exp, input int got);
      tests_run++;
      if (got != exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic pulse_load(input logic rd, input logic [31:0] word);
      @(negedge clk);
      rd_word = word;
      ident_word = word;
      rd_load = rd;
      ident_load = !rd;
      @(negedge clk);
      rd_load = 1'b0;
      ident_load = 1'b0;
      repeat (3) @(negedge clk);
   endtask

   task automatic t_reset_ident();
      logic [31:0] w;
      host.walk(8'h1f, 5);
      chk_vec("bridge_reset", 32'h1, {31'h0, bridge.reset});
      chk_vec("user_tms", {31'h0, tms}, {31'h0, user_tms});
      chk_vec("user_tdi", {31'h0, tdi}, {31'h0, user_tdi});
      chk_vec("user_tck", {31'h0, tck}, {31'h0, user_tck});
      chk_vec("tdo_oe_n_idle", 32'h1, {31'h0, tdo_oe_n});
      chk_vec("boot_mode", 32'h5, {29'h0, boot_mode});
      host.walk(8'h00, 1);
      host.scan_dr(32'h0, 32, w);
      chk_vec("ident_after_reset", ID_SET | 32'h1, w);
      host.scan_ir(OP_IDENT, w[5:0]);
      host.scan_dr(32'hffffffff, 32, w);
      chk_vec("ident_word", ID_SET | 32'h1, w);
   endtask

   task automatic t_ir_capture();
      logic [5:0] cap;
      for (int k = 0; k < 2; k++) begin
         @(negedge clk);
         status = (k == 0) ? 4'ha : 4'h5;
         repeat (3) @(negedge clk);
         host.scan_ir(OP_IDENT, cap);
         chk_vec("ir_capture", {26'h0, status, IR_CAP_FIXED}, {26'h0, cap});
      end
      @(negedge clk);
      status = '0;
   endtask

   // A user code before configuration and a reserved code must both fall back to bypass.
   task automatic t_bypass();
      logic [5:0] ops [3];
      logic [31:0] w;
      ops = '{OP_BYPASS, 6'h2a, USER_OPS[0]};
      for (int k = 0; k < 3; k++) begin
         host.scan_ir(ops[k], w[5:0]);
         chk_vec("sel_in_bypass", 32'h0, {28'h0, user_sel});
         host.scan_dr(32'hb5, 8, w);
         chk_vec("bypass_path", 32'h6a, w);
      end
   endtask

   task automatic t_design_ident();
      logic [31:0] w;
      pulse_load(1'b0, 32'h5a5a0c3f);
      host.scan_ir(OP_DESIGN_IDENT, w[5:0]);
      host.scan_dr(32'h0, 32, w);
      chk_vec("design_ident_blank", DESIGN_IDENT_RST, w);
      @(negedge clk);
      status.cfg_done = 1'b1;
      repeat (3) @(negedge clk);
      host.scan_dr(32'h0, 32, w);
      chk_vec("design_ident_loaded", 32'h5a5a0c3f, w);
   endtask

   task automatic t_cfg_access();
      logic [31:0] w;
      host.tap_reset();
      host.scan_ir(OP_CFG_LOAD, w[5:0]);
      wr_cnt = 0;
      host.scan_dr(32'hc3a51e69, 32, w);
      repeat (10) @(negedge clk);
      chk_cnt("cfg_wr_pulses", 1, wr_cnt);
      chk_vec("cfg_wr_word", 32'hc3a51e69, wr_seen);
      pulse_load(1'b1, 32'h7e812d4b);
      host.scan_ir(OP_CFG_READ, w[5:0]);
      host.scan_dr(32'h0, 32, w);
      chk_vec("readback_word", 32'h7e812d4b, w);
   endtask

   // Only the selected chain's user output is low, so any other chain shows ones and bypass shows its captured zero, then ones.
   task automatic t_user();
      logic [31:0] w;
      for (int i = 0; i < CHAINS; i++) begin
         user_tdo = ~(4'h1 << i);
         host.scan_ir(USER_OPS[i], w[5:0]);
         chk_vec("user_sel", {28'h0, 4'h1 << i}, {28'h0, user_sel});
         dr_shift_clock_out_cnt = '{default: 0};
         oe_cnt = 0;
         shf_cnt = 0;
         cap_cnt = 0;
         upd_cnt = 0;
         host.scan_dr(32'hff, 8, w);
         chk_vec("user_tdo_path", 32'h0, w);
         chk_cnt("dr_shift_clock_out_selected", 9, dr_shift_clock_out_cnt[i]);
         chk_cnt("dr_shift_clock_out_total", 9, dr_shift_clock_out_cnt.sum());
         chk_cnt("tdo_enable_bits", 8, oe_cnt);
         chk_cnt("bridge_shift", 8, shf_cnt);
         chk_cnt("bridge_capture", 1, cap_cnt);
         chk_cnt("bridge_update", 1, upd_cnt);
      end
      host.scan_ir(OP_BYPASS, w[5:0]);
      chk_vec("sel_after_user", 32'h0, {28'h0, user_sel});
   endtask

   initial begin
      fork
         repeat (5) @(negedge clk);
         host.walk(8'h1f, 5);
      join
      @(negedge clk);
      srst = 1'b0;
      repeat (3) @(negedge clk);
      host.tap_reset();
      t_reset_ident();
      t_ir_capture();
      t_bypass();
      t_design_ident();
      t_cfg_access();
      t_user();
      report_and_stop();
   end
endmodule
